// file: pvft_pkg.sv
// Constants shared by the parallel video source and its pixel FIFO.
`default_nettype none

package pvft_pkg;

  // Core clock rate and pixel clock divider.
  localparam int CORE_CLK_KHZ    = 40000;
  localparam int PCLK_DIV        = 4;

  // Bus and counter widths, and FIFO depth.
  localparam int PIXEL_W         = 24;
  localparam int CNT_W           = 12;
  localparam int FIFO_DEPTH      = 8;

  // Frame timing limits at the sink, in pixel clocks or lines.
  localparam int HSW_MIN         = 4;
  localparam int HSW_MAX         = 128;
  localparam int HBP_MIN         = 4;
  localparam int HFP_MIN         = 8;
  localparam int VSW_MIN         = 1;
  localparam int VBP_MIN         = 2;
  localparam int VFP_MIN         = 1;
  localparam int TVB_BASE        = 6;
  localparam int TVB_SCALE       = 8;

  // Default frame geometry of this source.
  localparam int H_ACTIVE_DEF    = 640;
  localparam int H_SYNC_DEF      = 8;
  localparam int H_BP_DEF        = 8;
  localparam int H_FP_DEF        = 16;
  localparam int V_ACTIVE_DEF    = 480;
  localparam int V_SYNC_DEF      = 2;
  localparam int V_BP_DEF        = 4;
  localparam int V_FP_DEF        = 4;
  localparam int DISP_LINES_DEF  = 480;

  // Stereo select setup and hold around each vsync transition.
  localparam int STEREO_SETUP_US = 1000;
  localparam int STEREO_HOLD_US  = 1000;
  localparam int STEREO_SETUP_CYC = (STEREO_SETUP_US * CORE_CLK_KHZ + 999) / 1000;
  localparam int STEREO_HOLD_CYC  = (STEREO_HOLD_US * CORE_CLK_KHZ + 999) / 1000;

  // Least total vertical blanking for a given source to display line ratio.
  function automatic int pvft_tvb_min(input int src_lines, input int disp_lines);
    int scaled;
    scaled = (TVB_SCALE * src_lines + disp_lines - 1) / disp_lines;
    if (scaled < TVB_SCALE)
      scaled = TVB_SCALE;
    return TVB_BASE + scaled;
  endfunction : pvft_tvb_min

endpackage : pvft_pkg

`default_nettype wire

// file: pvft_fifo.sv
// Pixel FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module pvft_fifo
  import pvft_pkg::*;
#(
  parameter int WIDTH = PIXEL_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire logic        push = in_valid && in_ready;
  wire logic        pop = out_valid && out_ready;
  wire logic [AW:0] next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);

  assign out_data  = store[rd_ptr];
  assign out_valid = (count != '0);

  always_ff @(posedge core_clk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == LAST_C) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == LAST_C) ? '0 : rd_ptr + 1'b1;
      count    <= next_count;
      in_ready <= (next_count < DEPTH_C);
    end
  end

endmodule : pvft_fifo

`default_nettype wire

// file: pvft_source.sv
// Parallel video source: pixel clock, syncs, qualifier, pixel bus and stereo select.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Vsync pulse lasts at least one line.
// - Vsync edge to first active hsync: 2 lines.
// - Last active line hsync to vsync: 1 line.
// - Vertical blanking at least 6 plus 8 times ratio.
// - Hsync pulse 4 to 128 pixel clocks.
// - Hsync edge to qualifier rise: 4 clocks.
// - Qualifier fall to next hsync: 8 clocks.
// - Outputs stable around rising pixel clock edge; stereo select may change on any core clock.
// - Stereo select settles 1 ms before vsync.
// - Stereo select held 1 ms after vsync.
module pvft_source
  import pvft_pkg::*;
#(
  parameter int H_ACTIVE   = H_ACTIVE_DEF,
  parameter int H_SYNC     = H_SYNC_DEF,
  parameter int H_BP       = H_BP_DEF,
  parameter int H_FP       = H_FP_DEF,
  parameter int V_ACTIVE   = V_ACTIVE_DEF,
  parameter int V_SYNC     = V_SYNC_DEF,
  parameter int V_BP       = V_BP_DEF,
  parameter int V_FP       = V_FP_DEF,
  parameter int DISP_LINES = DISP_LINES_DEF,
  parameter int SETUP_CYC  = STEREO_SETUP_CYC,
  parameter int HOLD_CYC   = STEREO_HOLD_CYC,
  parameter int DEPTH      = FIFO_DEPTH
) (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               video_enable,
  input  wire logic               vsync_active_high,
  input  wire logic               hsync_active_high,
  input  wire logic               stereo_req,
  input  wire logic [PIXEL_W-1:0] pix_in_data,
  input  wire logic               pix_in_valid,
  output var  logic               pix_in_ready,
  output var  logic               pclk,
  output var  logic               vsync,
  output var  logic               hsync,
  output var  logic               active_pixel_qualifier,
  output var  logic [PIXEL_W-1:0] pixel_bus,
  output var  logic               stereo_frame_select,
  output var  logic               underrun
);

  //////////////////////////////////////////////////////////////////////////////
  // Frame geometry.

  localparam int HALF      = PCLK_DIV / 2;
  localparam int H_TOTAL   = H_SYNC + H_BP + H_ACTIVE + H_FP;
  localparam int TVB_NEED  = pvft_tvb_min(V_ACTIVE, DISP_LINES);
  localparam int VB_LEAD   = V_SYNC + V_BP;
  localparam int V_FP_EFF  = (VB_LEAD + V_FP >= TVB_NEED) ? V_FP : TVB_NEED - VB_LEAD;
  localparam int V_TOTAL   = VB_LEAD + V_ACTIVE + V_FP_EFF;
  localparam int DE_START  = H_SYNC + H_BP;
  localparam int DE_STOP   = DE_START + H_ACTIVE;
  localparam logic [CNT_W-1:0] H_LAST_C  = CNT_W'(H_TOTAL - 1);
  localparam logic [CNT_W-1:0] V_LAST_C  = CNT_W'(V_TOTAL - 1);
  localparam logic [CNT_W-1:0] H_SYNC_C  = CNT_W'(H_SYNC);
  localparam logic [CNT_W-1:0] V_SYNC_C  = CNT_W'(V_SYNC);
  localparam logic [CNT_W-1:0] DE_STA_C  = CNT_W'(DE_START);
  localparam logic [CNT_W-1:0] DE_STO_C  = CNT_W'(DE_STOP);
  localparam logic [CNT_W-1:0] VA_STA_C  = CNT_W'(VB_LEAD);
  localparam logic [CNT_W-1:0] VA_STO_C  = CNT_W'(VB_LEAD + V_ACTIVE);
  localparam logic [3:0]       DIV_LAST  = 4'(PCLK_DIV - 1);
  localparam logic [3:0]       HALF_C    = 4'(HALF);
  localparam logic [31:0]      SETUP_C   = 32'(SETUP_CYC);
  localparam logic [31:0]      HOLD_C    = 32'(HOLD_CYC);
  localparam logic [31:0]      HT_C      = 32'(H_TOTAL);
  localparam logic [31:0]      DIV_C     = 32'(PCLK_DIV);

  //////////////////////////////////////////////////////////////////////////////
  // Pixel clock divider.

  logic [3:0] div_cnt;
  wire  logic [3:0] next_div_cnt = (div_cnt == DIV_LAST) ? 4'h0 : div_cnt + 4'h1;
  // outputs change on the falling pixel clock edge
  wire  logic tick = (next_div_cnt == HALF_C);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      div_cnt <= 4'h0;
      pclk    <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      pclk    <= (next_div_cnt < HALF_C);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pixel FIFO.

  logic [PIXEL_W-1:0] fifo_data;
  logic               fifo_valid;

  //////////////////////////////////////////////////////////////////////////////
  // Position counters and output decode.

  logic [CNT_W-1:0] hpos;
  logic [CNT_W-1:0] vpos;
  logic             running;

  wire logic at_origin = (hpos == '0) && (vpos == '0);
  wire logic live = at_origin ? video_enable : running;
  wire logic h_end = (hpos == H_LAST_C);
  wire logic [CNT_W-1:0] next_hpos = h_end ? '0 : hpos + 1'b1;
  wire logic [CNT_W-1:0] next_vpos = h_end ? ((vpos == V_LAST_C) ? '0 : vpos + 1'b1) : vpos;
  wire logic hs_on = live && (hpos < H_SYNC_C);
  wire logic vs_on = live && (vpos < V_SYNC_C);
  // one pixel per clock on active lines
  wire logic line_act = (vpos >= VA_STA_C) && (vpos < VA_STO_C);
  wire logic de_on = live && line_act && (hpos >= DE_STA_C) && (hpos < DE_STO_C);
  wire logic pop = tick && de_on;
  // sync polarity applied at the pins
  wire logic next_hsync = hs_on ~^ hsync_active_high;
  wire logic next_vsync = vs_on ~^ vsync_active_high;

  pvft_fifo #(
    .WIDTH     (PIXEL_W),
    .DEPTH     (DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_data   (pix_in_data),
    .in_valid  (pix_in_valid),
    .in_ready  (pix_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      hpos    <= '0;
      vpos    <= '0;
      running <= 1'b0;
    end
    else if (tick)
    begin
      running <= live;
      if (live)
      begin
        hpos <= next_hpos;
        vpos <= next_vpos;
      end
    end
  end

  // all bus outputs register on the same edge
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      // Syncs rest at their inactive level so that no false pulse follows reset.
      hsync                  <= !hsync_active_high;
      vsync                  <= !vsync_active_high;
      active_pixel_qualifier <= 1'b0;
      pixel_bus              <= '0;
      underrun               <= 1'b0;
    end
    else if (tick)
    begin
      hsync                  <= next_hsync;
      vsync                  <= next_vsync;
      active_pixel_qualifier <= de_on;
      pixel_bus              <= (de_on && fifo_valid) ? fifo_data : '0;
      underrun               <= underrun || (de_on && !fifo_valid);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stereo select scheduling.

  logic [31:0] since_vs;
  logic        stereo_pend;

  wire logic [31:0] pos_ticks = 32'(vpos) * HT_C + 32'(hpos);
  wire logic [31:0] edge_ticks = (vpos < V_SYNC_C) ? 32'(V_SYNC) * HT_C : 32'(V_TOTAL) * HT_C;
  wire logic [31:0] left_cyc = (edge_ticks - pos_ticks) * DIV_C;
  wire logic vs_flip = tick && (next_vsync != vsync);
  // hold after the last vsync transition
  wire logic hold_ok = (since_vs >= HOLD_C);
  // setup before the next vsync transition
  wire logic setup_ok = running && (left_cyc >= SETUP_C + DIV_C);
  wire logic stereo_go = stereo_pend && hold_ok && setup_ok && !vs_flip;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      since_vs            <= 32'h0;
      stereo_pend         <= 1'b0;
      stereo_frame_select <= 1'b0;
    end
    else
    begin
      since_vs            <= vs_flip ? 32'h0 : (hold_ok ? since_vs : since_vs + 32'h1);
      stereo_pend         <= (stereo_req != stereo_frame_select) && !stereo_go;
      stereo_frame_select <= stereo_go ? stereo_req : stereo_frame_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the driven pins.

  logic [31:0] hs_len;
  logic [31:0] hs_gap;
  logic [31:0] de_gap;
  logic [31:0] vs_lines;
  logic [31:0] st_age;
  logic [31:0] vs_age;
  logic [31:0] vb_cnt;
  logic [31:0] fp_lines;
  logic        hs_act_q;
  logic        vs_act_q;

  wire logic hs_act = (hsync == hsync_active_high);
  wire logic vs_act = (vsync == vsync_active_high);
  wire logic hs_rise = hs_act && !hs_act_q;
  wire logic vs_rise = vs_act && !vs_act_q;
  wire logic next_hs_act_w = (next_hsync == hsync_active_high);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      hs_len   <= 32'h0;
      hs_gap   <= 32'hffff;
      de_gap   <= 32'hffff;
      vs_lines <= 32'h0;
      st_age   <= 32'hffff_ffff;
      vs_age   <= 32'hffff_ffff;
      vb_cnt   <= 32'h0;
      fp_lines <= 32'hffff;
      hs_act_q <= 1'b0;
      vs_act_q <= 1'b0;
    end
    else
    begin
      // Edge history is kept per pixel clock so that every edge is seen on a tick.
      if (tick)
      begin
        hs_act_q <= hs_act;
        vs_act_q <= vs_act;
        vb_cnt   <= vs_rise ? 32'h0 : vb_cnt + 32'(hs_rise);
        fp_lines <= active_pixel_qualifier ? 32'h0 : fp_lines + 32'(hs_rise);
        hs_len <= hs_act ? hs_len + 32'h1 : 32'h0;
        hs_gap <= hs_rise ? 32'h1 : hs_gap + 32'h1;
        de_gap <= active_pixel_qualifier ? 32'h1 : de_gap + 32'h1;
        vs_lines <= !vs_act ? 32'h0 : vs_lines + 32'(hs_rise);
      end
      st_age <= $changed(stereo_frame_select) ? 32'h0 : st_age + 32'(st_age != 32'hffff_ffff);
      vs_age <= $changed(vsync) ? 32'h0 : vs_age + 32'(vs_age != 32'hffff_ffff);
    end
  end

  a_hsync_width: assert property (@(posedge core_clk) disable iff (reset)
    (tick && hs_act && !next_hs_act_w) |-> (hs_len + 32'h1 >= 32'(HSW_MIN)) && (hs_len + 32'h1 <= 32'(HSW_MAX)))
    else $error("hsync pulse width out of range");

  a_back_porch: assert property (@(posedge core_clk) disable iff (reset)
    (tick && de_on && !active_pixel_qualifier) |-> (hs_gap + 32'h1 >= 32'(HBP_MIN)))
    else $error("qualifier rose too soon after hsync");

  a_front_porch: assert property (@(posedge core_clk) disable iff (reset)
    (tick && next_hs_act_w && !hs_act) |-> (de_gap >= 32'(HFP_MIN)))
    else $error("hsync came too soon after qualifier fell");

  a_vsync_width: assert property (@(posedge core_clk) disable iff (reset)
    (tick && vs_act && (next_vsync != vsync_active_high)) |-> (vs_lines >= 32'(VSW_MIN)))
    else $error("vsync pulse shorter than a line");

  a_vert_porch: assert property (@(posedge core_clk) disable iff (reset)
    (tick && de_on && !active_pixel_qualifier) |-> (vb_cnt >= 32'(VBP_MIN)))
    else $error("vertical back porch too short");

  a_vert_front: assert property (@(posedge core_clk) disable iff (reset)
    (tick && vs_rise) |-> (fp_lines >= 32'(VFP_MIN)))
    else $error("vertical front porch too short");

  a_vert_blank: assert property (@(posedge core_clk) disable iff (reset)
    (tick && at_origin && live) |-> (32'(V_TOTAL - V_ACTIVE) >= 32'(TVB_NEED)))
    else $error("total vertical blanking too short");

  a_pins_stable: assert property (@(posedge core_clk) disable iff (reset)
    ($changed(pixel_bus) || $changed(hsync) || $changed(active_pixel_qualifier)) |-> !pclk ##1 !pclk)
    else $error("bus changed away from falling pixel clock");

  a_stereo_hold: assert property (@(posedge core_clk) disable iff (reset)
    $changed(stereo_frame_select) |-> (vs_age >= HOLD_C))
    else $error("stereo select changed too soon after vsync");

  a_stereo_setup: assert property (@(posedge core_clk) disable iff (reset)
    $changed(vsync) |-> (st_age >= SETUP_C))
    else $error("stereo select changed too close before vsync");

endmodule : pvft_source

`default_nettype wire

// file: pvft_sink_model.sv
// Behavioural parallel video sink that samples the port and records its frame timing.
`timescale 1ns/1ps
`default_nettype none

module pvft_sink_model
  import pvft_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               reset,
  input wire logic               vs_high,
  input wire logic               hs_high,
  input wire logic               pclk,
  input wire logic               vsync,
  input wire logic               hsync,
  input wire logic               active_pixel_qualifier,
  input wire logic [PIXEL_W-1:0] pixel_bus,
  input wire logic               stereo_frame_select
);
  localparam int BIG = 1 << 30;
  int                 tp, tc, t_vs, t_hs, t_qr, t_qf, t_af, t_vc, t_st, vbp, nlines;
  int                 hsw_min, hbp_min, hfp_min, vsw_min, vbp_min, vfp_min, tvb_min, su_min, ho_min;
  int                 hsw_max, lines, ppl, frames, n_st;
  logic               p_pclk, p_vs, p_hs, p_q, p_vc, p_st, qf_ok, af_ok, line_act, first, st_pend;
  logic               px_stb;
  logic [PIXEL_W-1:0] px_val;
  wire                vs_act = (vsync == vs_high);
  wire                hs_act = (hsync == hs_high);
  wire                q      = active_pixel_qualifier;
  wire                rise   = pclk && !p_pclk;

  function automatic int mn(int a, int b);
    return (a < b) ? a : b;
  endfunction : mn

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    p_pclk <= pclk;
    px_stb <= 1'b0;
    if (reset)
    begin
      {tp, tc, t_vs, t_hs, t_qr, t_qf, t_af, t_vc, t_st, vbp, nlines} <= '0;
      {hsw_min, hbp_min, hfp_min, vsw_min, vbp_min, vfp_min, tvb_min, su_min, ho_min} <= {9{BIG}};
      {hsw_max, lines, ppl, frames, n_st} <= '0;
      {p_vs, p_hs, p_q, p_vc, p_st, qf_ok, af_ok, line_act, first, st_pend} <= '0;
    end
    else
    begin
      tc <= tc + 1;
      p_vc <= vs_act;
      p_st <= stereo_frame_select;
      if (stereo_frame_select != p_st)
      begin
        n_st <= n_st + 1;
        t_st <= tc;
        st_pend <= 1'b1;
        ho_min <= mn(ho_min, tc - t_vc);
      end
      if (vs_act != p_vc)
      begin
        t_vc <= tc;
        st_pend <= 1'b0;
        if (st_pend)
          su_min <= mn(su_min, tc - t_st);
      end
      if (rise)
      begin
        tp <= tp + 1;
        p_vs <= vs_act;
        p_hs <= hs_act;
        p_q <= q;
        if (q)
        begin
          px_stb <= 1'b1;
          px_val <= pixel_bus;
        end
        if (vs_act && !p_vs)
        begin
          if (af_ok)
          begin
            vfp_min <= mn(vfp_min, tp - t_af);
            tvb_min <= mn(tvb_min, vbp + tp - t_af);
          end
          if (nlines > 0)
            lines <= nlines;
          frames <= frames + 1;
          t_vs <= tp;
          nlines <= 0;
          first <= 1'b1;
          af_ok <= 1'b0;
        end
        if (!vs_act && p_vs)
          vsw_min <= mn(vsw_min, tp - t_vs);
        if (hs_act && !p_hs)
        begin
          if (qf_ok)
            hfp_min <= mn(hfp_min, tp - t_qf);
          if (line_act)
          begin
            t_af <= tp;
            af_ok <= 1'b1;
          end
          t_hs <= tp;
          line_act <= 1'b0;
        end
        if (!hs_act && p_hs)
        begin
          hsw_min <= mn(hsw_min, tp - t_hs);
          hsw_max <= (tp - t_hs > hsw_max) ? tp - t_hs : hsw_max;
        end
        if (q && !p_q)
        begin
          hbp_min <= mn(hbp_min, tp - t_hs);
          nlines <= nlines + 1;
          line_act <= 1'b1;
          t_qr <= tp;
          if (first)
          begin
            vbp <= t_hs - t_vs;
            vbp_min <= mn(vbp_min, t_hs - t_vs);
            first <= 1'b0;
          end
        end
        if (!q && p_q)
        begin
          t_qf <= tp;
          qf_ok <= 1'b1;
          ppl <= tp - t_qr;
        end
      end
    end
  end
endmodule : pvft_sink_model

`default_nettype wire

// file: pvft_source_bench.sv
// Self-checking bench for the parallel video source against a behavioural sink.
`timescale 1ns/1ps
`default_nettype none

module pvft_source_bench;
  import pvft_pkg::*;
  localparam int HA = 8, HS = 4, HB = 4, HF = 8, VA = 4, LINE = HS + HB + HA + HF, BIG = 1 << 30;
  logic               core_clk = 1'b0, reset = 1'b1, video_enable = 1'b0, stereo_req = 1'b0;
  logic               vsync_active_high = 1'b1, hsync_active_high = 1'b1, sink_rst = 1'b1, feed = 1'b0;
  logic               pix_in_valid = 1'b0;
  logic [PIXEL_W-1:0] pix_in_data = 24'h000000, seq = 24'h000100;
  wire logic          pix_in_ready, pclk, vsync, hsync, active_pixel_qualifier, stereo_frame_select, underrun;
  wire logic [23:0]   pixel_bus;
  int                 fails = 0, n_compared = 0, n_zero = 0;
  logic [PIXEL_W-1:0] exp_q[$];

  always #12.5 core_clk = ~core_clk;

  pvft_source #(.H_ACTIVE(HA), .H_SYNC(HS), .H_BP(HB), .H_FP(HF), .V_ACTIVE(VA), .V_SYNC(1), .V_BP(2),
    .V_FP(1), .DISP_LINES(VA), .SETUP_CYC(200), .HOLD_CYC(200), .DEPTH(FIFO_DEPTH)) i_dut (
    .core_clk, .reset, .video_enable, .vsync_active_high, .hsync_active_high, .stereo_req,
    .pix_in_data, .pix_in_valid, .pix_in_ready, .pclk, .vsync, .hsync, .active_pixel_qualifier,
    .pixel_bus, .stereo_frame_select, .underrun);

  pvft_sink_model i_sink (.core_clk, .reset(sink_rst), .vs_high(vsync_active_high),
    .hs_high(hsync_active_high), .pclk, .vsync, .hsync, .active_pixel_qualifier, .pixel_bus,
    .stereo_frame_select);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_bit(string what, logic exp, logic got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp_word(string what, logic [PIXEL_W-1:0] exp, logic [PIXEL_W-1:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_range(string what, int lo, int hi, int got);
    n_compared++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("FAIL %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask : cmp_range

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Pixel feeder holds each word until the FIFO takes it.
  always @(posedge core_clk)
  begin
    if (pix_in_valid && pix_in_ready === 1'b1)
    begin
      exp_q.push_back(pix_in_data);
      seq = seq + 24'h000001;
    end
    pix_in_valid <= feed;
    pix_in_data <= seq;
  end

  always @(posedge core_clk)
    if (i_sink.px_stb === 1'b1)
    begin
      if (exp_q.size() > 0)
        cmp_word("pixel", exp_q.pop_front(), i_sink.px_val);
      else
      begin
        n_zero++;
        cmp_word("underrun pixel", 24'h000000, i_sink.px_val);
      end
    end

  task automatic do_reset(logic pol);
    @(posedge core_clk);
    reset <= 1'b1;
    sink_rst <= 1'b1;
    feed <= 1'b0;
    video_enable <= 1'b0;
    stereo_req <= 1'b0;
    vsync_active_high <= pol;
    hsync_active_high <= pol;
    repeat (20) @(posedge core_clk);
    exp_q.delete();
    reset <= 1'b0;
    repeat (8) @(posedge core_clk);
    sink_rst <= 1'b0;
    cmp_bit("hsync idle", ~pol, hsync);
    cmp_bit("vsync idle", ~pol, vsync);
  endtask : do_reset

  task automatic run_frames(int n);
    int target;
    int k;
    target = i_sink.frames + n;
    for (k = 0; k < 3000 * n && i_sink.frames < target; k++)
      @(posedge core_clk);
    cmp_range("frames seen", target, BIG, i_sink.frames);
  endtask : run_frames

  task automatic t_fifo_fill;
    cmp_bit("ready after reset", 1'b1, pix_in_ready);
    feed <= 1'b1;
    repeat (20) @(posedge core_clk);
    cmp_bit("ready when full", 1'b0, pix_in_ready);
    cmp_range("words taken", FIFO_DEPTH, FIFO_DEPTH, exp_q.size());
  endtask : t_fifo_fill

  task automatic t_frames(logic st);
    video_enable <= 1'b1;
    stereo_req <= st;
    feed <= 1'b1;
    run_frames(3);
    cmp_range("hsync width", HSW_MIN, HSW_MAX, i_sink.hsw_min);
    cmp_range("hsync width max", HSW_MIN, HSW_MAX, i_sink.hsw_max);
    cmp_range("h back porch", HBP_MIN, BIG, i_sink.hbp_min);
    cmp_range("h front porch", HFP_MIN, BIG, i_sink.hfp_min);
    cmp_range("vsync width", VSW_MIN * LINE, BIG, i_sink.vsw_min);
    cmp_range("v back porch", VBP_MIN * LINE, BIG, i_sink.vbp_min);
    cmp_range("v front porch", VFP_MIN * LINE, BIG, i_sink.vfp_min);
    cmp_range("v blanking", (TVB_BASE + TVB_SCALE) * LINE, BIG, i_sink.tvb_min);
    cmp_range("active lines", VA, VA, i_sink.lines);
    cmp_range("pixels per line", HA, HA, i_sink.ppl);
    cmp_bit("stereo select", st, stereo_frame_select);
    cmp_range("stereo changes", int'(st), int'(st), i_sink.n_st);
    cmp_range("stereo setup", 200, BIG, i_sink.su_min);
    cmp_range("stereo hold", 200, BIG, i_sink.ho_min);
    cmp_bit("no underrun", 1'b0, underrun);
  endtask : t_frames

  task automatic t_underrun;
    feed <= 1'b0;
    run_frames(2);
    cmp_bit("underrun flag", 1'b1, underrun);
    cmp_range("zero pixels", 1, BIG, n_zero);
  endtask : t_underrun

  initial
  begin
    repeat (60000) @(posedge core_clk);
    fails++;
    print_verdict();
  end

  initial
  begin
    do_reset(1'b1);
    t_fifo_fill();
    t_frames(1'b1);
    do_reset(1'b0);
    t_frames(1'b0);
    t_underrun();
    print_verdict();
  end
endmodule : pvft_source_bench

`default_nettype wire
